// *** cca_defs.vh ***
// constants for the two-module counter array: register addresses,
// control bit positions and reset values
// assumes inclusion by the single design file of the block
`ifndef CCA_DEFS_VH
`define CCA_DEFS_VH

// ----------------------------------------------------------------
// register addresses on the special-function register port
// ----------------------------------------------------------------
`define CCA_ADDR_ROUTE  8'hA2
`define CCA_ADDR_CTRL   8'hD8
`define CCA_ADDR_MODE   8'hD9
`define CCA_ADDR_MM0    8'hDA
`define CCA_ADDR_MM1    8'hDB
`define CCA_ADDR_CNTL   8'hE9
`define CCA_ADDR_CNTH   8'hF9
`define CCA_ADDR_CMPL0  8'hEA
`define CCA_ADDR_CMPL1  8'hEB
`define CCA_ADDR_CMPH0  8'hFA
`define CCA_ADDR_CMPH1  8'hFB
`define CCA_ADDR_NINE0  8'hF2
`define CCA_ADDR_NINE1  8'hF3

// ----------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------
`define CCA_CTRL_OVF    7
`define CCA_CTRL_RUN    6
`define CCA_MODE_IDLE   7
`define CCA_MODE_EXTCNT 1
`define CCA_MODE_OVFIE  0
`define CCA_ROUTE_RELOC 6
`define CCA_MM_CMPEN    6
`define CCA_MM_RISE     5
`define CCA_MM_FALL     4
`define CCA_MM_MATCH    3
`define CCA_MM_TOGGLE   2
`define CCA_MM_PWM      1
`define CCA_MM_IRQEN    0
`define CCA_NINE_ACT    0
`define CCA_NINE_STG    1

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define CCA_ROUTE_MASK  8'h7D
`define CCA_MODE_MASK   8'h8F
`define CCA_MM_MASK     8'h7F
`define CCA_ZERO8       8'h00
`define CCA_ZERO16      16'h0000
`define CCA_ONES16      16'hFFFF
`define CCA_LOW_WRAP    8'hFF
`define CCA_PIN_RST     1'b0

`endif

// *** cca_counter_array.v ***
// two-module counter array: shared 16-bit counter, capture, software
// timer, toggle output and 8-bit pulse-width output per module
// assumes a cpu-side register port on the same clock, and pins that
// are asynchronous to that clock
//
// What this block does
// - relocation bit moves count and module pins
// - two modules, four selectable modes each
// - counter advances only while run bit set
// - overflow sets flag; interrupt if enabled
// - overflow flag cleared only by software
// - idle-stop bit halts counting in idle
// - module flag set by hardware, software-cleared
// - module flag interrupts only when enabled
// - toggle bit inverts pin on match
// - match bit sets flag on match
// - edge arm bits; comparator enable bit
// - mode bits decode to operating mode
// - pulse mode flags on chosen output edges, only while the interrupt enable bit is set
// - capture copies counter, sets flag
// - software timer flags on equality
// - high-speed output toggles on equality
// - pulse modules share counter frequency
// - output low while low byte below duty
// - duty reloads when low byte wraps
// - counter and compare bytes reset zero
// - software may also set overflow flag
`include "cca_defs.vh"

module cca_counter_array (
	input  wire       clock,
	input  wire       rst,
	input  wire [7:0] sfr_addr,
	input  wire       sfr_wr,
	input  wire [7:0] sfr_wdata,
	input  wire       sfr_rd,
	output reg  [7:0] sfr_rdata,
	input  wire       count_tick,
	input  wire       cpu_idle,
	output wire       irq_req,
	input  wire       ext_count_dflt,
	input  wire       ext_count_alt,
	input  wire [1:0] pin_dflt_in,
	output wire [1:0] pin_dflt_out,
	output wire [1:0] pin_dflt_oe,
	input  wire [1:0] pin_alt_in,
	output wire [1:0] pin_alt_out,
	output wire [1:0] pin_alt_oe
);

	// ----------------------------------------------------------------
	// shared state
	// ----------------------------------------------------------------
	reg  [15:0] cnt_q;
	reg  [15:0] cnt_d;
	reg         ovf_q;
	reg         run_q;
	reg  [7:0]  mode_q;
	reg  [7:0]  route_q;
	reg  [1:0]  eci_s1_q;
	reg  [1:0]  eci_s2_q;
	reg         eci_p_q;
	wire        eci_sel;
	wire [15:0] cnt_inc;
	wire        tick;
	wire        adv;
	wire        wrap_low;
	wire        reloc;
	wire        ctrl_wr;
	wire [1:0]  ccf;
	wire [1:0]  pin_out;
	wire [1:0]  pin_drv;
	wire [1:0]  mod_irq;
	wire [15:0] mm_v;
	wire [15:0] cmpl_v;
	wire [15:0] cmph_v;
	wire [3:0]  nine_v;

	assign reloc   = route_q[`CCA_ROUTE_RELOC];
	assign ctrl_wr = sfr_wr && (sfr_addr == `CCA_ADDR_CTRL);
	assign cnt_inc = cnt_q + 16'h0001;

	// ----------------------------------------------------------------
	// external count input: two flops per pin, then the route mux
	// ----------------------------------------------------------------
	// switching the route bit may show one false edge; software is expected
	// to relocate only while the counter is stopped
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			eci_s1_q <= 2'b00;
			eci_s2_q <= 2'b00;
			eci_p_q  <= 1'b0;
		end else begin
			eci_s1_q <= {ext_count_alt, ext_count_dflt};
			eci_s2_q <= eci_s1_q;
			eci_p_q  <= eci_sel;
		end
	end

	// the route mux sits after the second flop, so no logic sees a raw pin
	assign eci_sel = reloc ? eci_s2_q[1] : eci_s2_q[0];

	// count source: internal tick or a rising edge on the count pin
	assign tick = mode_q[`CCA_MODE_EXTCNT] ? (eci_sel & ~eci_p_q) : count_tick;
	// run gating and idle stop
	assign adv  = run_q && tick && !(mode_q[`CCA_MODE_IDLE] && cpu_idle);
	assign wrap_low = adv && (cnt_q[7:0] == `CCA_LOW_WRAP);

	// ----------------------------------------------------------------
	// shared counter; a software write to a byte wins over the increment
	// ----------------------------------------------------------------
	always @* begin
		cnt_d = adv ? cnt_inc : cnt_q;
		if (sfr_wr && (sfr_addr == `CCA_ADDR_CNTL))
			cnt_d = {cnt_d[15:8], sfr_wdata};
		if (sfr_wr && (sfr_addr == `CCA_ADDR_CNTH))
			cnt_d = {sfr_wdata, cnt_d[7:0]};
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= `CCA_ZERO16;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// control, mode and routing registers
	// ----------------------------------------------------------------
	// overflow flag: software may write either value, overflow sets it
	// and wins over a clear in the same cycle
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			ovf_q   <= 1'b0;
			run_q   <= 1'b0;
			mode_q  <= `CCA_ZERO8;
			route_q <= `CCA_ZERO8;
		end else begin
			if (ctrl_wr) begin
				ovf_q <= sfr_wdata[`CCA_CTRL_OVF];
				run_q <= sfr_wdata[`CCA_CTRL_RUN];
			end
			if (adv && (cnt_q == `CCA_ONES16))
				ovf_q <= 1'b1;
			if (sfr_wr && (sfr_addr == `CCA_ADDR_MODE))
				mode_q <= sfr_wdata & `CCA_MODE_MASK;
			if (sfr_wr && (sfr_addr == `CCA_ADDR_ROUTE))
				route_q <= sfr_wdata & `CCA_ROUTE_MASK;
		end
	end

	// one request line for overflow and both module flags
	assign irq_req = (ovf_q & mode_q[`CCA_MODE_OVFIE]) | (|mod_irq);

	// ----------------------------------------------------------------
	// per-module logic
	// ----------------------------------------------------------------
	genvar m;
	generate
		for (m = 0; m < 2; m = m + 1) begin : g_mod
			reg  [7:0] mm_q;
			reg  [7:0] cmpl_q;
			reg  [7:0] cmph_q;
			reg        nact_q;
			reg        nstg_q;
			reg        flag_q;
			reg        out_q;
			reg  [1:0] s1_q;
			reg  [1:0] s2_q;
			reg        p_q;
			wire       pin_sel;
			wire       cmp_en;
			wire       rise_arm;
			wire       fall_arm;
			wire       pwm_mode;
			wire       cap_mode;
			wire       match;
			wire       pin_rise;
			wire       pin_fall;
			wire       cap_ev;
			wire       pwm_lvl;
			wire       pwm_ev;
			wire       flag_set;

			// mode decode
			assign cmp_en   = mm_q[`CCA_MM_CMPEN];
			assign rise_arm = mm_q[`CCA_MM_RISE];
			assign fall_arm = mm_q[`CCA_MM_FALL];
			assign pwm_mode = cmp_en & mm_q[`CCA_MM_PWM];
			assign cap_mode = (rise_arm | fall_arm) & ~mm_q[`CCA_MM_MATCH]
				& ~mm_q[`CCA_MM_TOGGLE] & ~mm_q[`CCA_MM_PWM];

			// match when the counter steps onto the compare value, so a
			// stopped counter does not re-fire every clock
			assign match = cmp_en && !mm_q[`CCA_MM_PWM] && adv
				&& (cnt_inc == {cmph_q, cmpl_q});

			// each pin is synchronised on its own; the route picks one after
			assign pin_sel  = reloc ? s2_q[1] : s2_q[0];
			assign pin_rise = pin_sel & ~p_q;
			assign pin_fall = ~pin_sel & p_q;
			assign cap_ev   = cap_mode && ((rise_arm && pin_rise)
				|| (fall_arm && pin_fall));

			// pulse level: low while low byte is below the nine-bit duty
			assign pwm_lvl = ({1'b0, cnt_q[7:0]} >= {nact_q, cmpl_q});
			assign pwm_ev  = pwm_mode && mm_q[`CCA_MM_IRQEN]
				&& ((rise_arm && pwm_lvl && !out_q)
				|| (fall_arm && !pwm_lvl && out_q));

			assign flag_set = cap_ev || pwm_ev
				|| (match && mm_q[`CCA_MM_MATCH]);

			always @(posedge clock or posedge rst) begin
				if (rst) begin
					s1_q <= 2'b00;
					s2_q <= 2'b00;
					p_q  <= 1'b0;
				end else begin
					s1_q <= {pin_alt_in[m], pin_dflt_in[m]};
					s2_q <= s1_q;
					p_q  <= pin_sel;
				end
			end

			// mode register and event flag; hardware set wins over clear
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					mm_q   <= `CCA_ZERO8;
					flag_q <= 1'b0;
				end else begin
					if (sfr_wr && (sfr_addr == (m ? `CCA_ADDR_MM1 : `CCA_ADDR_MM0)))
						mm_q <= sfr_wdata & `CCA_MM_MASK;
					if (ctrl_wr)
						flag_q <= sfr_wdata[m];
					if (flag_set)
						flag_q <= 1'b1;
				end
			end

			// compare bytes and ninth bits; capture and reload win over writes
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					cmpl_q <= `CCA_ZERO8;
					cmph_q <= `CCA_ZERO8;
					nact_q <= 1'b0;
					nstg_q <= 1'b0;
				end else begin
					if (sfr_wr && (sfr_addr == (m ? `CCA_ADDR_CMPL1 : `CCA_ADDR_CMPL0)))
						cmpl_q <= sfr_wdata;
					if (sfr_wr && (sfr_addr == (m ? `CCA_ADDR_CMPH1 : `CCA_ADDR_CMPH0)))
						cmph_q <= sfr_wdata;
					if (sfr_wr && (sfr_addr == (m ? `CCA_ADDR_NINE1 : `CCA_ADDR_NINE0))) begin
						nact_q <= sfr_wdata[`CCA_NINE_ACT];
						nstg_q <= sfr_wdata[`CCA_NINE_STG];
					end
					if (cap_ev) begin
						cmph_q <= cnt_q[15:8];
						cmpl_q <= cnt_q[7:0];
					end
					if (pwm_mode && wrap_low) begin
						cmpl_q <= cmph_q;
						nact_q <= nstg_q;
					end
				end
			end

			// pin latch: pulse level, or inversion on match in toggle mode;
			// every pulse module follows the one shared counter
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					out_q <= `CCA_PIN_RST;
				end else if (pwm_mode) begin
					out_q <= pwm_lvl;
				end else if (match && mm_q[`CCA_MM_TOGGLE]) begin
					out_q <= ~out_q;
				end
			end

			assign pin_out[m] = out_q;
			assign pin_drv[m] = pwm_mode | (cmp_en & mm_q[`CCA_MM_TOGGLE]);
			assign ccf[m]     = flag_q;
			assign mod_irq[m] = flag_q & mm_q[`CCA_MM_IRQEN];
			assign mm_v[m*8 +: 8]   = mm_q;
			assign cmpl_v[m*8 +: 8] = cmpl_q;
			assign cmph_v[m*8 +: 8] = cmph_q;
			assign nine_v[m*2 +: 2] = {nstg_q, nact_q};
		end
	endgenerate

	// ----------------------------------------------------------------
	// pin routing
	// ----------------------------------------------------------------
	// the unselected pin is released, never driven
	assign pin_dflt_out = pin_out;
	assign pin_alt_out  = pin_out;
	assign pin_dflt_oe  = reloc ? 2'b00 : pin_drv;
	assign pin_alt_oe   = reloc ? pin_drv : 2'b00;

	// ----------------------------------------------------------------
	// read port: data one clock after the read strobe, unmapped reads zero
	// ----------------------------------------------------------------
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sfr_rdata <= `CCA_ZERO8;
		end else if (sfr_rd) begin
			if (sfr_addr == `CCA_ADDR_CTRL)
				sfr_rdata <= {ovf_q, run_q, 4'h0, ccf};
			else if (sfr_addr == `CCA_ADDR_MODE)
				sfr_rdata <= mode_q;
			else if (sfr_addr == `CCA_ADDR_ROUTE)
				sfr_rdata <= route_q;
			else if (sfr_addr == `CCA_ADDR_MM0)
				sfr_rdata <= mm_v[7:0];
			else if (sfr_addr == `CCA_ADDR_MM1)
				sfr_rdata <= mm_v[15:8];
			else if (sfr_addr == `CCA_ADDR_CNTL)
				sfr_rdata <= cnt_q[7:0];
			else if (sfr_addr == `CCA_ADDR_CNTH)
				sfr_rdata <= cnt_q[15:8];
			else if (sfr_addr == `CCA_ADDR_CMPL0)
				sfr_rdata <= cmpl_v[7:0];
			else if (sfr_addr == `CCA_ADDR_CMPL1)
				sfr_rdata <= cmpl_v[15:8];
			else if (sfr_addr == `CCA_ADDR_CMPH0)
				sfr_rdata <= cmph_v[7:0];
			else if (sfr_addr == `CCA_ADDR_CMPH1)
				sfr_rdata <= cmph_v[15:8];
			else if (sfr_addr == `CCA_ADDR_NINE0)
				sfr_rdata <= {6'h00, nine_v[1:0]};
			else if (sfr_addr == `CCA_ADDR_NINE1)
				sfr_rdata <= {6'h00, nine_v[3:2]};
			else
				sfr_rdata <= `CCA_ZERO8;
		end
	end

endmodule

// *** cca_properties.sv ***
// port checker for the counter array
// assumes it is bound onto cca_counter_array, one clock domain
// ----
// checks
// ----
module cca_properties (
	input wire       clock,
	input wire       rst,
	input wire       sfr_wr,
	input wire [7:0] sfr_rdata,
	input wire       count_tick,
	input wire       irq_req,
	input wire [1:0] pin_dflt_in,
	input wire [1:0] pin_alt_in,
	input wire [1:0] pin_dflt_out,
	input wire [1:0] pin_dflt_oe,
	input wire [1:0] pin_alt_out,
	input wire [1:0] pin_alt_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [4:0] hist_q;
	reg [3:0] pins_p_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// recent causes a flag may follow; capture lags a pin by three edges
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			hist_q   <= 5'h00;
			pins_p_q <= 4'h0;
		end else begin
			hist_q   <= {hist_q[3:0], sfr_wr | count_tick | ({pin_dflt_in, pin_alt_in} != pins_p_q)};
			pins_p_q <= {pin_dflt_in, pin_alt_in};
		end
	end
	reset_rdata_a: assert property (disable iff (1'b0) rst |=> sfr_rdata == 8'h00 && !irq_req)
		else $error("read data or request not clear in reset");
	reset_pins_a: assert property (disable iff (1'b0) rst |-> {pin_dflt_out, pin_alt_out,
		pin_dflt_oe, pin_alt_oe} == 8'h00)
		else $error("pins not clear in reset");
	oe_exclusive_a: assert property ((pin_dflt_oe != 2'b00) |-> (pin_alt_oe == 2'b00))
		else $error("both pin groups driven");
	out_copy_a: assert property (pin_dflt_out == pin_alt_out)
		else $error("pin groups disagree");
	oe_write_a: assert property (!$stable({pin_dflt_oe, pin_alt_oe}) |-> $past(sfr_wr))
		else $error("drive enable moved without a write");
	irq_fall_a: assert property ($fell(irq_req) |-> $past(sfr_wr))
		else $error("request dropped without a write");
	irq_cause_a: assert property ($rose(irq_req) |-> hist_q != 5'h00)
		else $error("request rose without cause");
	out_cause_a: assert property ($changed(pin_dflt_out) |-> $past(count_tick)
		|| $past(count_tick, 2) || $past(sfr_wr) || $past(sfr_wr, 2))
		else $error("pin moved without tick or write");
endmodule

bind cca_counter_array cca_properties i_props (.clock(clock), .rst(rst), .sfr_wr(sfr_wr),
	.sfr_rdata(sfr_rdata), .count_tick(count_tick), .irq_req(irq_req),
	.pin_dflt_in(pin_dflt_in), .pin_alt_in(pin_alt_in), .pin_dflt_out(pin_dflt_out),
	.pin_dflt_oe(pin_dflt_oe), .pin_alt_out(pin_alt_out), .pin_alt_oe(pin_alt_oe));

// *** cca_pins_model.sv ***
// outside sources on the module pins
// assumes the bench sets the level each source drives
module cca_pins_model (
	input  wire [1:0] drv_dflt,
	input  wire [1:0] drv_alt,
	input  wire [1:0] drv_eci,
	input  wire [1:0] pin_dflt_out,
	input  wire [1:0] pin_dflt_oe,
	input  wire [1:0] pin_alt_out,
	input  wire [1:0] pin_alt_oe,
	output wire [1:0] pin_dflt_in,
	output wire [1:0] pin_alt_in,
	output wire       ext_count_dflt,
	output wire       ext_count_alt
);
	timeunit 1ns;
	timeprecision 1ps;
	// a driving module owns the wire, else the outside source sets it
	assign pin_dflt_in = (pin_dflt_oe & pin_dflt_out) | (~pin_dflt_oe & drv_dflt);
	assign pin_alt_in = (pin_alt_oe & pin_alt_out) | (~pin_alt_oe & drv_alt);
	// count pins follow the bench; bit 0 default route, bit 1 relocated
	assign ext_count_dflt = drv_eci[0];
	assign ext_count_alt = drv_eci[1];
endmodule

// *** counter_array_capture_compare_pwm_tb.sv ***
// self-checking bench for the counter array
// assumes the pin model and bound checker are compiled first
module counter_array_capture_compare_pwm_tb;
	timeunit 1ns;
	timeprecision 1ps;
	reg         clock = 1'b0;
	reg         rst = 1'b1;
	reg  [7:0]  sfr_addr = 8'h00;
	reg         sfr_wr = 1'b0;
	reg  [7:0]  sfr_wdata = 8'h00;
	reg         sfr_rd = 1'b0;
	reg         count_tick = 1'b0;
	reg         cpu_idle = 1'b0;
	reg  [1:0]  drv_dflt = 2'b00;
	reg  [1:0]  drv_alt = 2'b00;
	reg  [1:0]  drv_eci = 2'b00;
	reg  [15:0] v;
	reg  [7:0]  mm;
	wire [7:0]  sfr_rdata;
	wire        irq_req, ext_count_dflt, ext_count_alt;
	wire [1:0]  pin_dflt_in, pin_alt_in, pin_dflt_out, pin_dflt_oe, pin_alt_out, pin_alt_oe;
	integer     bad_count = 0;
	integer     check_count = 0;
	integer     seed = 89740;
	integer     cycles = 0;
	integer     i, m, n;
	initial forever #12.5 clock = ~clock;
	cca_counter_array i_dut (.clock(clock), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.count_tick(count_tick), .cpu_idle(cpu_idle), .irq_req(irq_req),
		.ext_count_dflt(ext_count_dflt), .ext_count_alt(ext_count_alt),
		.pin_dflt_in(pin_dflt_in), .pin_dflt_out(pin_dflt_out), .pin_dflt_oe(pin_dflt_oe),
		.pin_alt_in(pin_alt_in), .pin_alt_out(pin_alt_out), .pin_alt_oe(pin_alt_oe));
	cca_pins_model i_pins (.drv_dflt(drv_dflt), .drv_alt(drv_alt), .drv_eci(drv_eci),
		.pin_dflt_out(pin_dflt_out), .pin_dflt_oe(pin_dflt_oe), .pin_alt_out(pin_alt_out),
		.pin_alt_oe(pin_alt_oe), .pin_dflt_in(pin_dflt_in), .pin_alt_in(pin_alt_in),
		.ext_count_dflt(ext_count_dflt), .ext_count_alt(ext_count_alt));
	// ----
	// bus cycles and comparison
	// ----
	function [15:0] nxt(input [15:0] a, input integer k);
		nxt = a + k;
	endfunction
	task cmp8(input [7:0] got, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("FAIL %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(negedge clock);
			sfr_addr = a;
			sfr_wdata = d;
			sfr_wr = 1'b1;
			@(negedge clock);
			sfr_wr = 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		begin
			@(negedge clock);
			sfr_addr = a;
			sfr_rd = 1'b1;
			@(negedge clock);
			sfr_rd = 1'b0;
			cmp8(sfr_rdata, exp);
		end
	endtask
	// ticks stay high for k rising edges
	task tick(input integer k);
		begin
			@(negedge clock);
			count_tick = 1'b1;
			repeat (k) @(negedge clock);
			count_tick = 1'b0;
		end
	endtask
	// output lags the counter by one clock, so look two later
	task pwm(input [7:0] cl, input [7:0] e);
		begin
			wr(8'hE9, cl);
			repeat (2) @(negedge clock);
			cmp8({7'h00, pin_dflt_out[0]}, e);
		end
	endtask
	task report_and_stop;
		begin
			if (bad_count == 0 && check_count > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// hang guard, far above the sequence length
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			bad_count = bad_count + 1;
			report_and_stop;
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		repeat (2) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		rd(8'h10, 8'h00);
		for (i = 0; i < 8; i = i + 1)
			rd(64'hD8D9E9F9EAEBFAFB >> (i * 8), 8'h00);
		wr(8'hE9, 8'hFE);
		wr(8'hF9, 8'hFF);
		wr(8'hD8, 8'h40);
		tick(2);
		rd(8'hD8, 8'hC0);
		rd(8'hF9, 8'h00);
		wr(8'hD9, 8'h01);
		cmp8({7'h00, irq_req}, 8'h01);
		wr(8'hD8, 8'h00);
		tick(3);
		rd(8'hE9, 8'h00);
		cmp8({7'h00, irq_req}, 8'h00);
		wr(8'hD8, 8'h80);
		rd(8'hD8, 8'h80);
		wr(8'hD9, 8'h80);
		wr(8'hD8, 8'h40);
		cpu_idle = 1'b1;
		tick(4);
		rd(8'hE9, 8'h00);
		cpu_idle = 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			v = $random(seed);
			n = 1 + {$random(seed)} % 20;
			wr(8'hE9, v[7:0]);
			wr(8'hF9, v[15:8]);
			tick(n);
			v = nxt(v, n);
			rd(8'hE9, v[7:0]);
			rd(8'hF9, v[15:8]);
		end
		// external count pin on the default route; the relocated pin is ignored
		wr(8'hD9, 8'h02);
		wr(8'hE9, 8'h00);
		wr(8'hF9, 8'h00);
		for (i = 0; i < 3; i = i + 1) begin
			repeat (4) @(negedge clock);
			drv_eci = 2'b01;
			repeat (4) @(negedge clock);
			drv_eci = 2'b00;
		end
		repeat (4) @(negedge clock);
		drv_eci = 2'b10;
		repeat (6) @(negedge clock);
		rd(8'hE9, 8'h03);
		drv_eci = 2'b00;
		wr(8'hD9, 8'h00);
		// timer with toggle, module 1 on the relocated pins
		for (m = 0; m < 2; m = m + 1) begin
			wr(8'hA2, m ? 8'h40 : 8'h00);
			wr(8'hD8, 8'h00);
			v = $random(seed) & 16'h7FFF;
			wr(8'hE9, v[7:0]);
			wr(8'hF9, v[15:8]);
			v = nxt(v, 3);
			wr(8'hEA + m, v[7:0]);
			wr(8'hFA + m, v[15:8]);
			wr(8'hDA + m, 8'h4D);
			wr(8'hD8, 8'h40);
			tick(2);
			rd(8'hD8, 8'h40);
			tick(1);
			rd(8'hD8, 8'h40 | (8'h01 << m));
			cmp8({6'h00, m ? pin_alt_oe : pin_dflt_oe}, 8'h01 << m);
			cmp8({7'h00, pin_dflt_out[m]}, 8'h01);
			cmp8({7'h00, irq_req}, 8'h01);
			wr(8'hDA + m, 8'h4C);
			cmp8({7'h00, irq_req}, 8'h00);
			rd(8'hD8, 8'h40 | (8'h01 << m));
			wr(8'hDA + m, 8'h00);
		end
		// capture on module 1 for each edge choice
		for (i = 0; i < 3; i = i + 1) begin
			mm = 24'h201030 >> (i * 8);
			wr(8'hA2, i[0] ? 8'h40 : 8'h00);
			wr(8'hD8, 8'h00);
			wr(8'hDB, mm);
			v = $random(seed);
			wr(8'hE9, v[7:0]);
			wr(8'hF9, v[15:8]);
			if (i[0]) drv_alt = 2'b10; else drv_dflt = 2'b10;
			repeat (6) @(negedge clock);
			rd(8'hD8, {6'h00, mm[5], 1'b0});
			if (mm[5]) rd(8'hEB, v[7:0]);
			if (mm[5]) rd(8'hFB, v[15:8]);
			wr(8'hD8, 8'h00);
			if (i[0]) drv_alt = 2'b00; else drv_dflt = 2'b00;
			repeat (6) @(negedge clock);
			rd(8'hD8, {6'h00, mm[4], 1'b0});
		end
		// pulse width on module 0, duty staged in the high byte
		wr(8'hA2, 8'h00);
		wr(8'hDB, 8'h00);
		wr(8'hD8, 8'h00);
		wr(8'hEA, 8'h80);
		wr(8'hFA, 8'h40);
		wr(8'hDA, 8'h42);
		cmp8({6'h00, pin_dflt_oe}, 8'h01);
		pwm(8'h7F, 8'h00);
		pwm(8'h80, 8'h01);
		pwm(8'hFF, 8'h01);
		wr(8'hD8, 8'h40);
		tick(1);
		wr(8'hD8, 8'h00);
		pwm(8'h3F, 8'h00);
		pwm(8'h40, 8'h01);
		rd(8'hEA, 8'h40);
		wr(8'hF2, 8'h02);
		pwm(8'hFF, 8'h01);
		wr(8'hD8, 8'h40);
		tick(1);
		wr(8'hD8, 8'h00);
		pwm(8'hFF, 8'h00);
		rd(8'hF2, 8'h03);
		// pulse flag on the rising output edge only
		wr(8'hF2, 8'h00);
		wr(8'hD8, 8'h00);
		wr(8'hDA, 8'h63);
		pwm(8'h3F, 8'h00);
		pwm(8'h40, 8'h01);
		rd(8'hD8, 8'h01);
		wr(8'hD8, 8'h00);
		pwm(8'h3F, 8'h00);
		rd(8'hD8, 8'h00);
		report_and_stop;
	end
endmodule
